/* pkg/ndc_regs.svh */
`ifndef NDC_REGS_SVH
`define NDC_REGS_SVH

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define NDC_CMD_SET_DEFAULT   8'hc1
`define NDC_CMD_CLEAR_A       8'hc2
`define NDC_CMD_CLEAR_B       8'hc3
`define NDC_CMD_RESET_GAIN    8'hd5
`define NDC_CMD_ADJ_REG       8'hd6
`define NDC_CMD_CAL_MOD       8'hd7
`define NDC_CMD_CAL_ANT       8'hd8
`define NDC_CMD_MEAS_PHASE    8'hd9
`define NDC_CMD_CLR_RSSI      8'hda
`define NDC_CMD_CAL_CAP       8'hdd
`define NDC_CMD_MEAS_CAP      8'hde
`define NDC_CMD_MASK_RX_TMR   8'he2
`define NDC_CMD_TEST_ACCESS   8'hfc

// ----------------------------------------------------------------------------
// Operation control field positions and reset values
// ----------------------------------------------------------------------------
`define NDC_OPC_EN_BIT        3'd7
`define NDC_OPC_RESET         8'h00
`define NDC_GAIN_RESET        4'h0
`define NDC_TRIM_RESET        8'h00
`define NDC_MOD_RESET         8'h00

// ----------------------------------------------------------------------------
// Timing counts of the engines
// ----------------------------------------------------------------------------
`define NDC_OP_TIME_NS        32'd1000
`define NDC_OP_CYCLES         16'd100
`define NDC_ANT_STEPS         4'd8

`endif

/* pkg/ndc_pkg.sv */
package ndc_pkg;

    // Decoder states, one hot.
    typedef enum logic [2:0] {
        NDC_IDLE = 3'b001,
        NDC_BUSY = 3'b010,
        NDC_DONE = 3'b100
    } ndc_state_t;

    // Long-running operation that is in progress.
    typedef enum logic [2:0] {
        NDC_OP_NONE  = 3'h0,
        NDC_OP_REG   = 3'h1,
        NDC_OP_MOD   = 3'h2,
        NDC_OP_ANT   = 3'h3,
        NDC_OP_PHASE = 3'h4,
        NDC_OP_CCAL  = 3'h5,
        NDC_OP_CMEAS = 3'h6
    } ndc_op_t;

endpackage

/* verilog/ndc_op_timer.sv */
`timescale 1ns/10ps
`include "ndc_regs.svh"

// ----------------------------------------------------------------------------
// Operation timer
// ----------------------------------------------------------------------------
module ndc_op_timer (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        start_i,
    input  wire logic        abort_i,
    output logic             busy_o,
    output logic             done_o
);
    logic [15:0] count;

    // Counts a fixed operation time and pulses done at its end.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || abort_i) begin
            count  <= 16'h0000;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else if (start_i) begin
            count  <= `NDC_OP_CYCLES;
            busy_o <= 1'b1;
            done_o <= 1'b0;
        end else if (busy_o && count == 16'h0001) begin
            count  <= 16'h0000;
            busy_o <= 1'b0;
            done_o <= 1'b1;
        end else begin
            count  <= busy_o ? count - 16'h0001 : count;
            done_o <= 1'b0;
        end
    end
endmodule

/* verilog/ndc_decoder.sv */
`timescale 1ns/10ps
`include "ndc_regs.svh"

// How it works
// R1: Gain reset reloads manual gain from receiver config; needs enable; no interrupt.
// R2: Regulator adjust interrupts when done; refused if external regulator select set.
// R3: Modulation calibration enables transmitter, adjusts depth, interrupts when done.
// R4: Antenna calibration steps trim capacitors to resonance; needs enable; interrupts.
// R5: Phase measurement compares transmit and receive signals; needs enable; interrupts.
// R6: Signal strength clear restarts measurement; chaining allowed; no interrupt.
// R7: Capacitive calibration accepted in any mode when manual select is zero.
// R8: Capacitance measurement accepted in every mode and interrupts when done.
// R9: Mask receive timer start accepted only in initial active target mode.
// R10: Test access unlocks test register writes in any mode; no interrupt.
// R11: Commands whose required control bits are not all set are ignored.
// R12: Set default resets registers except the two IO configs and control.
// R13: Set default also drops stored calibration and adjustment results.
// R14: Set default accepted always; FIFO kept untouched when enable clear.
// R15: Nothing may follow set default; it raises no interrupt.
// R16: Clear aborts transfers, empties FIFO, stops timers but wake-up and EMV timer.
// R17: Clear also resets collision display and interrupt registers.
// R18: Host issues clear before loading FIFO for ordinary transmissions.
// R19: Clear accepted only with enable set and oscillator stable.
// R20: Clear allows chaining and raises no interrupt.
// R21: Code c1 is set default.
// R22: Codes c2 and c3 are clear.
// R23: Unused and test-reserved codes are ignored without any effect.
module ndc_decoder
    import ndc_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        cmd_valid_i,
    input  wire logic [7:0]  cmd_code_i,
    input  wire logic [7:0]  op_ctrl_i,
    input  wire logic        xtal_stable_i,
    input  wire logic        ext_reg_sel_i,
    input  wire logic        cap_manual_cal_i,
    input  wire logic        active_target_init_i,
    input  wire logic        nrt_emv_i,
    input  wire logic [3:0]  manual_gain_i,
    input  wire logic        resonance_i,
    output logic             cmd_accepted_o,
    output logic             cmd_rejected_o,
    output logic             busy_o,
    output logic             irq_o,
    output logic             chain_ok_o,
    output logic             set_default_o,
    output logic             clear_fifo_o,
    output logic             abort_txrx_o,
    output logic             stop_timers_o,
    output logic             stop_nrt_o,
    output logic             clear_irq_regs_o,
    output logic             clear_coll_o,
    output logic             rssi_clear_o,
    output logic             mask_rx_start_o,
    output logic             test_access_o,
    output logic             tx_on_o,
    output logic [3:0]       rx_gain_o,
    output logic [7:0]       antenna_trim_cap_pins_o,
    output logic [7:0]       mod_depth_o,
    output logic             reg_adjusted_o,
    output logic             phase_valid_o,
    output logic             cap_valid_o
);

    // ------------------------------------------------------------------------
    // Acceptance check
    // ------------------------------------------------------------------------

    // Returns whether the code is one this block decodes.
    function automatic logic is_known(input logic [7:0] c);
        case (c)
            `NDC_CMD_SET_DEFAULT, `NDC_CMD_CLEAR_A, `NDC_CMD_CLEAR_B,
            `NDC_CMD_RESET_GAIN, `NDC_CMD_ADJ_REG, `NDC_CMD_CAL_MOD,
            `NDC_CMD_CAL_ANT, `NDC_CMD_MEAS_PHASE, `NDC_CMD_CLR_RSSI,
            `NDC_CMD_CAL_CAP, `NDC_CMD_MEAS_CAP, `NDC_CMD_MASK_RX_TMR,
            `NDC_CMD_TEST_ACCESS: is_known = 1'b1;
            default: is_known = 1'b0;
        endcase
    endfunction

    logic en;
    logic mode_ok;
    logic take;
    logic engine_busy;
    logic timer_busy;
    logic timer_done;
    logic timer_start;
    logic timer_abort;
    ndc_state_t state;
    ndc_op_t    op;
    ndc_op_t    next_op;

    assign en = op_ctrl_i[`NDC_OPC_EN_BIT];

    // Required control bits per command; unknown codes never pass.
    always_comb begin
        mode_ok = 1'b0;
        next_op = NDC_OP_NONE;
        case (cmd_code_i)
            `NDC_CMD_SET_DEFAULT: mode_ok = 1'b1;                        // [R14] [R21]
            `NDC_CMD_CLEAR_A,
            `NDC_CMD_CLEAR_B:     mode_ok = en && xtal_stable_i;          // [R19] [R22]
            `NDC_CMD_RESET_GAIN:  mode_ok = en;                           // [R1] [R11]
            `NDC_CMD_ADJ_REG: begin
                mode_ok = en && !ext_reg_sel_i;                           // [R2]
                next_op = NDC_OP_REG;
            end
            `NDC_CMD_CAL_MOD: begin
                mode_ok = en;                                             // [R3]
                next_op = NDC_OP_MOD;
            end
            `NDC_CMD_CAL_ANT: begin
                mode_ok = en;                                             // [R4]
                next_op = NDC_OP_ANT;
            end
            `NDC_CMD_MEAS_PHASE: begin
                mode_ok = en;                                             // [R5]
                next_op = NDC_OP_PHASE;
            end
            `NDC_CMD_CLR_RSSI:    mode_ok = en;                           // [R6]
            `NDC_CMD_CAL_CAP: begin
                mode_ok = !cap_manual_cal_i;                              // [R7]
                next_op = NDC_OP_CCAL;
            end
            `NDC_CMD_MEAS_CAP: begin
                mode_ok = 1'b1;                                           // [R8]
                next_op = NDC_OP_CMEAS;
            end
            `NDC_CMD_MASK_RX_TMR: mode_ok = active_target_init_i;         // [R9]
            `NDC_CMD_TEST_ACCESS: mode_ok = 1'b1;                         // [R10]
            default:              mode_ok = 1'b0;                         // [R23]
        endcase
    end

    // A new command is taken only while no engine runs, except set default and clear.
    assign engine_busy = (state != NDC_IDLE);
    assign take = cmd_valid_i && mode_ok && is_known(cmd_code_i) &&
                  (!engine_busy || cmd_code_i == `NDC_CMD_SET_DEFAULT ||
                   cmd_code_i == `NDC_CMD_CLEAR_A || cmd_code_i == `NDC_CMD_CLEAR_B); // [R11]

    assign timer_start = take && (next_op != NDC_OP_NONE);
    assign timer_abort = take && (cmd_code_i == `NDC_CMD_SET_DEFAULT);

    ndc_op_timer u_timer (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .start_i   (timer_start),
        .abort_i   (timer_abort),
        .busy_o    (timer_busy),
        .done_o    (timer_done)
    );

    // ------------------------------------------------------------------------
    // Operation sequencer
    // ------------------------------------------------------------------------

    // Tracks the running engine and raises the completion interrupt.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state <= NDC_IDLE;
            op    <= NDC_OP_NONE;
            irq_o <= 1'b0;
        end else begin
            irq_o <= 1'b0;
            case (state)
                NDC_IDLE: begin
                    if (timer_start) begin
                        state <= NDC_BUSY;
                        op    <= next_op;
                    end
                end
                NDC_BUSY: begin
                    if (timer_abort) begin
                        state <= NDC_IDLE;                                // [R15]
                        op    <= NDC_OP_NONE;
                    end else if (timer_done) begin
                        state <= NDC_DONE;
                    end
                end
                NDC_DONE: begin
                    irq_o <= 1'b1;                                        // [R2] [R3] [R4] [R5] [R8]
                    state <= NDC_IDLE;
                    op    <= NDC_OP_NONE;
                end
                default: begin
                    state <= NDC_IDLE;
                    op    <= NDC_OP_NONE;
                end
            endcase
        end
    end

    // Busy flag for the host.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= timer_start || (timer_busy && !timer_abort);
        end
    end

    // ------------------------------------------------------------------------
    // Command strobes
    // ------------------------------------------------------------------------

    // One-cycle action strobes and acceptance report.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cmd_accepted_o   <= 1'b0;
            cmd_rejected_o   <= 1'b0;
            chain_ok_o       <= 1'b0;
            set_default_o    <= 1'b0;
            clear_fifo_o     <= 1'b0;
            abort_txrx_o     <= 1'b0;
            stop_timers_o    <= 1'b0;
            stop_nrt_o       <= 1'b0;
            clear_irq_regs_o <= 1'b0;
            clear_coll_o     <= 1'b0;
            rssi_clear_o     <= 1'b0;
            mask_rx_start_o  <= 1'b0;
        end else begin
            cmd_accepted_o   <= take;
            cmd_rejected_o   <= cmd_valid_i && !take;                     // [R11] [R23]
            chain_ok_o       <= take && (cmd_code_i == `NDC_CMD_CLEAR_A ||
                                         cmd_code_i == `NDC_CMD_CLEAR_B ||
                                         cmd_code_i == `NDC_CMD_CLR_RSSI ||
                                         cmd_code_i == `NDC_CMD_MASK_RX_TMR ||
                                         cmd_code_i == `NDC_CMD_TEST_ACCESS); // [R6] [R9] [R10] [R20]
            set_default_o    <= take && cmd_code_i == `NDC_CMD_SET_DEFAULT;   // [R12]
            clear_fifo_o     <= take && (cmd_code_i == `NDC_CMD_CLEAR_A ||
                                         cmd_code_i == `NDC_CMD_CLEAR_B ||
                                         (cmd_code_i == `NDC_CMD_SET_DEFAULT && en)); // [R14] [R16]
            abort_txrx_o     <= take && (cmd_code_i == `NDC_CMD_CLEAR_A ||
                                         cmd_code_i == `NDC_CMD_CLEAR_B);     // [R16]
            stop_timers_o    <= take && (cmd_code_i == `NDC_CMD_CLEAR_A ||
                                         cmd_code_i == `NDC_CMD_CLEAR_B);     // [R16]
            stop_nrt_o       <= take && !nrt_emv_i &&
                                (cmd_code_i == `NDC_CMD_CLEAR_A ||
                                 cmd_code_i == `NDC_CMD_CLEAR_B);             // [R16]
            clear_irq_regs_o <= take && (cmd_code_i == `NDC_CMD_CLEAR_A ||
                                         cmd_code_i == `NDC_CMD_CLEAR_B);     // [R17]
            clear_coll_o     <= take && (cmd_code_i == `NDC_CMD_CLEAR_A ||
                                         cmd_code_i == `NDC_CMD_CLEAR_B);     // [R17]
            rssi_clear_o     <= take && cmd_code_i == `NDC_CMD_CLR_RSSI;      // [R6]
            mask_rx_start_o  <= take && cmd_code_i == `NDC_CMD_MASK_RX_TMR;   // [R9]
        end
    end

    // Test register write unlock; dropped by set default.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            test_access_o <= 1'b0;
        end else if (take && cmd_code_i == `NDC_CMD_SET_DEFAULT) begin
            test_access_o <= 1'b0;                                        // [R12]
        end else if (take && cmd_code_i == `NDC_CMD_TEST_ACCESS) begin
            test_access_o <= 1'b1;                                        // [R10]
        end
    end

    // ------------------------------------------------------------------------
    // Receiver gain
    // ------------------------------------------------------------------------

    // Gain reset loads the manual reduction.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rx_gain_o <= `NDC_GAIN_RESET;
        end else if (take && cmd_code_i == `NDC_CMD_SET_DEFAULT) begin
            rx_gain_o <= `NDC_GAIN_RESET;                                 // [R12]
        end else if (take && cmd_code_i == `NDC_CMD_RESET_GAIN) begin
            rx_gain_o <= manual_gain_i;                                   // [R1]
        end
    end

    // ------------------------------------------------------------------------
    // Calibration engines and results
    // ------------------------------------------------------------------------

    // Transmitter is held on while the modulation calibration runs.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tx_on_o <= 1'b0;
        end else begin
            tx_on_o <= (timer_start && next_op == NDC_OP_MOD) ||
                       (state == NDC_BUSY && op == NDC_OP_MOD && !timer_abort && !timer_done); // [R3]
        end
    end

    // Antenna trim steps one capacitor up each cycle until resonance is seen or the pins reach ff, where it holds.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            antenna_trim_cap_pins_o <= `NDC_TRIM_RESET;
        end else if (timer_abort) begin
            antenna_trim_cap_pins_o <= `NDC_TRIM_RESET;                   // [R13]
        end else if (timer_start && next_op == NDC_OP_ANT) begin
            antenna_trim_cap_pins_o <= `NDC_TRIM_RESET;
        end else if (state == NDC_BUSY && op == NDC_OP_ANT && !resonance_i &&
                     antenna_trim_cap_pins_o != 8'hff) begin
            antenna_trim_cap_pins_o <= antenna_trim_cap_pins_o + 8'h01;   // [R4]
        end
    end

    // Stored results of the other engines, lost on set default.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || timer_abort) begin
            mod_depth_o    <= `NDC_MOD_RESET;                             // [R13]
            reg_adjusted_o <= 1'b0;
            phase_valid_o  <= 1'b0;
            cap_valid_o    <= 1'b0;
        end else if (state == NDC_DONE) begin
            if (op == NDC_OP_MOD) begin
                mod_depth_o <= mod_depth_o + 8'h01;                       // [R3]
            end
            if (op == NDC_OP_REG) begin
                reg_adjusted_o <= 1'b1;                                   // [R2]
            end
            if (op == NDC_OP_PHASE) begin
                phase_valid_o <= 1'b1;                                    // [R5]
            end
            if (op == NDC_OP_CCAL || op == NDC_OP_CMEAS) begin
                cap_valid_o <= 1'b1;                                      // [R7] [R8]
            end
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    chk_clear_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R19]
        abort_txrx_o |-> $past(en) && $past(xtal_stable_i))
        else $error("Clear taken without enable and stable oscillator.");
    chk_nrt_emv: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R16]
        stop_nrt_o |-> !$past(nrt_emv_i) && stop_timers_o)
        else $error("No-response timer stopped in EMV mode.");
    chk_default_fifo: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R14]
        (set_default_o && !$past(en)) |-> !clear_fifo_o)
        else $error("FIFO cleared by set default while disabled.");
    chk_gain_load: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R1]
        (take && cmd_code_i == `NDC_CMD_RESET_GAIN) |=> rx_gain_o == $past(manual_gain_i))
        else $error("Gain not loaded from manual value.");
    chk_reg_refuse: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R2]
        (cmd_valid_i && cmd_code_i == `NDC_CMD_ADJ_REG && ext_reg_sel_i) |=> cmd_rejected_o)
        else $error("Regulator adjust accepted with external select.");
    chk_unknown_ignored: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R23]
        (cmd_valid_i && !is_known(cmd_code_i)) |=> cmd_rejected_o && !cmd_accepted_o && !$rose(busy_o))
        else $error("Unused code had an effect.");
    // A set default aborts the engine and legally suppresses the interrupt.
    chk_op_irq: assert property (@(posedge sys_clk_i) disable iff (rst_i || timer_abort) // [R5]
        (timer_start && !engine_busy) |-> ##[100:103] irq_o)
        else $error("Operation completion interrupt missing.");
    chk_clear_noirq: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R20]
        (take && cmd_code_i == `NDC_CMD_CLEAR_A && !engine_busy) |=> !irq_o ##0 chain_ok_o)
        else $error("Clear raised interrupt or forbade chaining.");
    chk_default_wipe: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R13]
        set_default_o |-> mod_depth_o == `NDC_MOD_RESET && !phase_valid_o && !test_access_o)
        else $error("Set default kept results.");
    chk_mask_mode: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R9]
        mask_rx_start_o |-> $past(active_target_init_i))
        else $error("Mask timer started outside target mode.");

    cov_clear: cover property (@(posedge sys_clk_i) abort_txrx_o);
    cov_default: cover property (@(posedge sys_clk_i) set_default_o);
    cov_irq: cover property (@(posedge sys_clk_i) irq_o);
    cov_test: cover property (@(posedge sys_clk_i) $rose(test_access_o));
endmodule

/* tb/ndc_host_model.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Host model
// ----------------------------------------------------------------------------
module ndc_host_model (
    input  wire logic       sys_clk_i,
    input  wire logic       req_i,
    input  wire logic [7:0] req_code_i,
    output logic            cmd_valid_o,
    output logic [7:0]      cmd_code_o
);
    logic [7:0] last_code = 8'h00;

    // Between commands the code bus toggles so a stale byte is never mistaken for a command.
    always_ff @(posedge sys_clk_i) begin
        last_code <= req_i ? req_code_i : ~last_code;
    end

    // The request is passed through for exactly the cycle that the bench asks for.
    assign cmd_valid_o = req_i;
    assign cmd_code_o  = req_i ? req_code_i : last_code;
endmodule

/* tb/ndc_decoder_bench.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Decoder bench
// ----------------------------------------------------------------------------
module ndc_decoder_bench;
    import ndc_pkg::*;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, cmd_valid_i, xtal_stable_i, ext_reg_sel_i, cap_manual_cal_i, req = 1'b0;
    logic active_target_init_i, nrt_emv_i, resonance_i, cmd_accepted_o, cmd_rejected_o, busy_o, irq_o, chain_ok_o;
    logic set_default_o, clear_fifo_o, abort_txrx_o, stop_timers_o, stop_nrt_o, clear_irq_regs_o, clear_coll_o;
    logic rssi_clear_o, mask_rx_start_o, test_access_o, tx_on_o, reg_adjusted_o, phase_valid_o, cap_valid_o;
    logic [7:0] cmd_code_i, op_ctrl_i, req_code = 8'h00, antenna_trim_cap_pins_o, mod_depth_o;
    logic [3:0] manual_gain_i, rx_gain_o;
    int         err_total = 0, checked = 0, seed = 32'h8a615cf8;
    logic [7:0] codes [17] = '{8'hc1, 8'hc2, 8'hc3, 8'hd5, 8'hd6, 8'hd7, 8'hd8, 8'hd9, 8'hda, 8'hdd, 8'hde,
                               8'he2, 8'hfc, 8'hd2, 8'hdc, 8'hf0, 8'h00};

    ndc_decoder ndc_decoder_inst (.*);
    ndc_host_model ndc_host_model_inst (.sys_clk_i(sys_clk_i), .req_i(req), .req_code_i(req_code),
                                        .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i));

    // The clock toggles every half period of 5 ns.
    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // Acceptance follows the mode bits that each command needs; only set default and clear pass while busy.
    function automatic logic exp_acc(input logic [7:0] c, input logic bz);
        if (bz && c != 8'hc1 && c != 8'hc2 && c != 8'hc3) return 1'b0;
        case (c)
            8'hc1, 8'hde, 8'hfc:                return 1'b1;
            8'hc2, 8'hc3:                       return op_ctrl_i[7] && xtal_stable_i;
            8'hd5, 8'hd7, 8'hd8, 8'hd9, 8'hda: return op_ctrl_i[7];
            8'hd6:                              return op_ctrl_i[7] && !ext_reg_sel_i;
            8'hdd:                              return !cap_manual_cal_i;
            8'he2:                              return active_target_init_i;
            default:                            return 1'b0;
        endcase
    endfunction

    // Compares one flag and counts the outcome.
    task automatic chk(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s is %b", $time, what, got);
        end
    endtask

    // Applies mode inputs off the sampling edge.
    task automatic set_modes(input logic [7:0] oc, input logic [4:0] m);
        @(negedge sys_clk_i);
        {op_ctrl_i, xtal_stable_i, ext_reg_sel_i, cap_manual_cal_i} = {oc, m[4:2]};
        {active_target_init_i, nrt_emv_i} = m[1:0];
        manual_gain_i = 4'($random(seed));
        resonance_i   = 1'($random(seed));
    endtask

    // Issues one command and checks strobes; engine commands are followed to their interrupt when wt is set.
    task automatic run(input logic [7:0] c, input logic wt);
        logic       a, e, clr, bz;
        logic [7:0] md;
        int         n;
        bz  = busy_o;
        md  = mod_depth_o;
        a   = exp_acc(c, bz);
        e   = a && (c inside {8'hd6, 8'hd7, 8'hd8, 8'hd9, 8'hdd, 8'hde});
        clr = a && (c == 8'hc2 || c == 8'hc3);
        n   = 0;
        req = 1'b1;
        req_code = c;
        @(negedge sys_clk_i);
        req = 1'b0;
        chk(cmd_accepted_o, a, "accepted");
        chk(cmd_rejected_o, !a, "rejected");
        chk(chain_ok_o, a && (clr || c inside {8'hda, 8'he2, 8'hfc}), "chain");
        chk(set_default_o, a && c == 8'hc1, "set default");
        chk(clear_fifo_o, clr || (a && c == 8'hc1 && op_ctrl_i[7]), "fifo clear");
        chk(rssi_clear_o, a && c == 8'hda, "rssi clear");
        chk(mask_rx_start_o, a && c == 8'he2, "mask start");
        chk(busy_o, e || (bz && c != 8'hc1), "busy");
        if (c != 8'hc1) begin
            chk(abort_txrx_o & stop_timers_o & clear_coll_o, clr, "abort");
            chk(stop_nrt_o, clr && !nrt_emv_i, "nrt stop");
            chk(clear_irq_regs_o, clr, "irq regs clear");
        end
        if (a && c == 8'hd5) chk(rx_gain_o === manual_gain_i, 1'b1, "gain");
        if (a && c == 8'hd7) chk(tx_on_o, 1'b1, "tx on");
        if (a && c == 8'hfc) chk(test_access_o, 1'b1, "test access");
        if (e && wt) begin
            while (irq_o !== 1'b1 && n < 110) begin
                @(negedge sys_clk_i);
                n++;
            end
            chk(irq_o && n == 102, 1'b1, "irq timing");
            if (c == 8'hd7) chk(mod_depth_o == md + 8'h01, 1'b1, "mod depth");
            if (c == 8'hd8) chk(antenna_trim_cap_pins_o == 8'h00, resonance_i, "trim");
            if (c == 8'hd9) chk(phase_valid_o, 1'b1, "phase");
            if (c == 8'hd6) chk(reg_adjusted_o, 1'b1, "regulator");
            if (c == 8'hdd || c == 8'hde) chk(cap_valid_o, 1'b1, "cap");
            n = 0;
            while (busy_o !== 1'b0 && n < 5) begin
                @(negedge sys_clk_i);
                n++;
            end
            chk(busy_o, 1'b0, "busy end");
        end
        // Request stays low for one clock before the next command.
        @(negedge sys_clk_i);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Main sequence: every code with all modes met, an abort while busy, then random traffic.
    initial begin
        int n;
        set_modes(8'h80, 5'b10011);
        repeat (16) @(negedge sys_clk_i);
        rst_i = 1'b0;
        run(8'hc3, 1'b1);
        foreach (codes[i]) run(codes[i], 1'b1);
        $display("test all codes done");
        run(8'hd9, 1'b0);
        run(8'hd5, 1'b1);
        run(8'hc1, 1'b1);
        for (n = 0; n < 110 && irq_o !== 1'b1; n++) @(negedge sys_clk_i);
        chk(irq_o | phase_valid_o | reg_adjusted_o | cap_valid_o | test_access_o, 1'b0, "wiped");
        chk(|{mod_depth_o, antenna_trim_cap_pins_o}, 1'b0, "results wiped");
        $display("test abort done");
        set_modes(8'h00, 5'b10000);
        run(8'hc1, 1'b1);
        run(8'hc2, 1'b1);
        $display("test disabled done");
        repeat (150) begin
            set_modes(8'($random(seed)), 5'($random(seed)));
            run(($random(seed) & 1) ? codes[{$random(seed)} % 17] : 8'($random(seed)), 1'b1);
        end
        $display("test random done");
        give_verdict();
    end
endmodule
